// ==== logic/icp_pipeline.v ====
/*
  Instruction cycle and pipeline control of a small 8-bit core with its
  8-bit arithmetic unit, accumulator and small data memory.
  Assumes program memory on core_clk_i returns the word at pm_addr_o
  by the last phase of the cycle in which it was requested.
*/
// What this block does
// - The system clock enable comes from the fast or the slow internal oscillator as selected.
// - The system clock is split into four phase clocks that never overlap.
// - At the start of the first phase the program counter advances and a new word is fetched.
// - Decode and execution run in the second, third and fourth phases.
// - One pass through the four phases is one instruction cycle.
// - Fetch of the next word overlaps execution so plain instructions take one cycle.
// - Standard instructions take one cycle, extended two, branches and calls one more.
// - A jump or call first takes its target, then branches and drops the prefetched word.
// - Any instruction that changes the program counter costs one extra cycle.
// - Arithmetic, logic, rotate, increment, decrement and skip tests use one 8-bit unit.
// - Data moves through the accumulator and unit; data memory is reached directly or indirectly.
// - A taken conditional skip drops the prefetched word and inserts a dummy cycle.
// - A write to the program counter low byte jumps within the 256-word page with a dummy cycle.
`timescale 1ns/1ps
`default_nettype none
`include "icp_consts.vh"

module icp_pipeline #(
  parameter           PC_W     = `ICP_PC_W,
  parameter           DM_AW    = `ICP_DM_AW,
  parameter [7:0]     SLOW_DIV = `ICP_SLOW_DIV
) (
  input  wire            core_clk_i,
  input  wire            rstn_i,
  input  wire            osc_sel_i,
  input  wire [15:0]     pm_data_i,
  output wire [PC_W-1:0] pm_addr_o,
  output wire            pm_rd_o,
  output wire [3:0]      quarter_phase_clocks_o,
  output wire            sys_tick_o,
  output wire            cycle_end_o,
  output wire            dummy_cycle_o,
  output wire [PC_W-1:0] exec_pc_o,
  output wire [7:0]      acc_o,
  output wire            call_push_o,
  output wire [PC_W-1:0] ret_addr_o
);

  // ****************************************************************
  // Reset release and clock source selection
  // ****************************************************************
  reg rst_sync1_ff;
  reg rst_n_ff;
  reg sel_meta_ff;
  reg sel_ff;
  reg [7:0] div_cnt_ff;
  wire      slow_tick;
  wire      sys_tick;

  always @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_sync1_ff <= 1'b0;
      rst_n_ff     <= 1'b0;
    end else begin
      rst_sync1_ff <= 1'b1;
      rst_n_ff     <= rst_sync1_ff;
    end
  end

  // Select pin may change at any time, so it is synchronised first
  always @(posedge core_clk_i or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      sel_meta_ff <= `ICP_SRC_FAST;
      sel_ff      <= `ICP_SRC_FAST;
      div_cnt_ff  <= 8'h00;
    end else begin
      sel_meta_ff <= osc_sel_i;
      sel_ff      <= sel_meta_ff;
      div_cnt_ff  <= slow_tick ? 8'h00 : div_cnt_ff + 8'h01;
    end
  end

  assign slow_tick = (div_cnt_ff == SLOW_DIV - 8'h01);
  // Fast source runs at the core rate, slow one is a divided enable
  assign sys_tick  = (sel_ff == `ICP_SRC_SLOW) ? slow_tick : 1'b1;

  // ****************************************************************
  // Phase generation
  // ****************************************************************
  wire [1:0] phase;
  wire       t2_tick;
  wire       t3_tick;
  wire       cyc_end;

  icp_phase_gen u_phase (
    .clk_i                  (core_clk_i),
    .rst_n_i                (rst_n_ff),
    .tick_i                 (sys_tick),
    .phase_o                (phase),
    .quarter_phase_clocks_o (quarter_phase_clocks_o)
  );

  assign t2_tick = sys_tick && (phase == `ICP_PH_T2);
  assign t3_tick = sys_tick && (phase == `ICP_PH_T3);
  assign cyc_end = sys_tick && (phase == `ICP_PH_T4);

  // ****************************************************************
  // Pipeline state
  // ****************************************************************
  reg [PC_W-1:0]  pc_ff;
  reg [PC_W-1:0]  ir_pc_ff;
  reg [15:0]      ir_ff;
  reg             bubble_ff;
  reg             ext_ff;
  reg [DM_AW-1:0] opnd_addr_ff;
  reg [7:0]       opnd_ff;
  reg [PC_W-1:0]  tgt_ff;
  reg [7:0]       acc_ff;
  reg             call_ff;
  reg [PC_W-1:0]  ret_addr_ff;
  reg [7:0]       dmem [0:(1<<DM_AW)-1];

  wire [3:0] opc;
  assign opc = ir_ff[`ICP_OPC_HI:`ICP_OPC_LO];

  // ****************************************************************
  // Arithmetic unit and pipeline decisions
  // ****************************************************************
  reg [7:0]      alu_res;
  reg            acc_we;
  reg            dm_we;
  reg            stall;
  reg            flush;
  reg            redirect;
  reg [PC_W-1:0] nxt_target;

  always @* begin
    alu_res    = acc_ff;
    acc_we     = 1'b0;
    dm_we      = 1'b0;
    stall      = 1'b0;
    flush      = 1'b0;
    redirect   = 1'b0;
    nxt_target = tgt_ff;
    if (!bubble_ff) begin
      case (opc)
        `ICP_OP_MOVI: begin
          alu_res = ir_ff[7:0];
          acc_we  = 1'b1;
        end
        `ICP_OP_ADD: begin
          alu_res = acc_ff + opnd_ff;
          acc_we  = 1'b1;
        end
        `ICP_OP_AND: begin
          alu_res = acc_ff & opnd_ff;
          acc_we  = 1'b1;
        end
        `ICP_OP_OR: begin
          alu_res = acc_ff | opnd_ff;
          acc_we  = 1'b1;
        end
        `ICP_OP_XOR: begin
          alu_res = acc_ff ^ opnd_ff;
          acc_we  = 1'b1;
        end
        `ICP_OP_RL: begin
          alu_res = {acc_ff[6:0], acc_ff[7]};
          acc_we  = 1'b1;
        end
        `ICP_OP_INC: begin
          alu_res = opnd_ff + 8'h01;
          dm_we   = 1'b1;
        end
        `ICP_OP_DEC: begin
          alu_res = opnd_ff - 8'h01;
          dm_we   = 1'b1;
        end
        `ICP_OP_MOVM: begin
          alu_res = acc_ff;
          dm_we   = 1'b1;
        end
        `ICP_OP_SZ: begin
          alu_res = opnd_ff;
          flush   = (alu_res == 8'h00);
        end
        `ICP_OP_MOVPCL: begin
          // Only the low byte moves, so the jump stays in the page
          redirect   = 1'b1;
          nxt_target = {ir_pc_ff[PC_W-1:`ICP_PCL_W], acc_ff};
        end
        `ICP_OP_LADD: begin
          stall   = !ext_ff;
          alu_res = acc_ff + opnd_ff;
          acc_we  = ext_ff;
        end
        `ICP_OP_JMP: begin
          redirect = 1'b1;
        end
        `ICP_OP_CALL: begin
          redirect = 1'b1;
        end
        default: begin
          alu_res = acc_ff;
        end
      endcase
    end
  end

  // ****************************************************************
  // Decode in the second phase, operand read in the third
  // ****************************************************************
  always @(posedge core_clk_i or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      opnd_addr_ff <= {DM_AW{1'b0}};
      opnd_ff      <= 8'h00;
      tgt_ff       <= `ICP_PC_RST;
    end else begin
      if (t2_tick) begin
        // Indirect access takes the address from data location zero
        opnd_addr_ff <= ir_ff[`ICP_IND_BIT] ? dmem[0][DM_AW-1:0]
                                             : ir_ff[DM_AW-1:0];
        tgt_ff       <= {ir_pc_ff[PC_W-1:`ICP_JT_W], ir_ff[`ICP_JT_W-1:0]};
      end
      if (t3_tick) begin
        opnd_ff <= dmem[opnd_addr_ff];
      end
    end
  end

  // ****************************************************************
  // Result write-back in the fourth phase
  // ****************************************************************
  integer i;
  always @(posedge core_clk_i or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      acc_ff <= `ICP_ACC_RST;
      for (i = 0; i < (1 << DM_AW); i = i + 1) begin
        dmem[i] <= 8'h00;
      end
    end else if (cyc_end) begin
      if (acc_we) begin
        acc_ff <= alu_res;
      end
      if (dm_we) begin
        dmem[opnd_addr_ff] <= alu_res;
      end
    end
  end

  // ****************************************************************
  // Fetch and program counter, stepped at each cycle boundary
  // ****************************************************************
  always @(posedge core_clk_i or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      pc_ff       <= `ICP_PC_RST;
      ir_pc_ff    <= `ICP_PC_RST;
      ir_ff       <= `ICP_NOP_WORD;
      bubble_ff   <= 1'b1;
      ext_ff      <= 1'b0;
      call_ff     <= 1'b0;
      ret_addr_ff <= `ICP_PC_RST;
    end else begin
      call_ff <= 1'b0;
      if (cyc_end) begin
        if (stall) begin
          // Extended word holds its place one more cycle, fetch repeats
          ext_ff <= 1'b1;
        end else begin
          ext_ff    <= 1'b0;
          ir_pc_ff  <= pc_ff;
          // Prefetched word is dropped when the flow changes
          ir_ff     <= (flush || redirect) ? `ICP_NOP_WORD : pm_data_i;
          bubble_ff <= flush || redirect;
          pc_ff     <= redirect ? nxt_target
                                : pc_ff + {{(PC_W-1){1'b0}}, 1'b1};
          if (!bubble_ff && (opc == `ICP_OP_CALL)) begin
            call_ff     <= 1'b1;
            ret_addr_ff <= ir_pc_ff + {{(PC_W-1){1'b0}}, 1'b1};
          end
        end
      end
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign pm_addr_o     = pc_ff;
  assign pm_rd_o       = quarter_phase_clocks_o[0];
  assign sys_tick_o    = sys_tick;
  assign cycle_end_o   = cyc_end;
  assign dummy_cycle_o = bubble_ff;
  assign exec_pc_o     = ir_pc_ff;
  assign acc_o         = acc_ff;
  assign call_push_o   = call_ff;
  assign ret_addr_o    = ret_addr_ff;

endmodule
`default_nettype wire

// ==== logic/icp_consts.vh ====
/*
  Shared constants of the instruction cycle pipeline: phase codes, opcode
  map of the instruction word, reset values and clock source settings.
  Assumes it is included by its bare name from the logic folder.
*/
`ifndef ICP_CONSTS_VH
`define ICP_CONSTS_VH

// ****************************************************************
// Phase codes, one instruction cycle is four phases
// ****************************************************************
`define ICP_PH_T1        2'h0
`define ICP_PH_T2        2'h1
`define ICP_PH_T3        2'h2
`define ICP_PH_T4        2'h3
`define ICP_NUM_PHASES   4

// ****************************************************************
// Clock source select and slow oscillator divide ratio
// ****************************************************************
`define ICP_SRC_FAST     1'b0
`define ICP_SRC_SLOW     1'b1
`define ICP_SLOW_DIV     8'h08

// ****************************************************************
// Widths and reset values
// ****************************************************************
`define ICP_PC_W         13
`define ICP_DM_AW        4
`define ICP_JT_W         12
`define ICP_PCL_W        8
`define ICP_PC_RST       13'h0000
`define ICP_ACC_RST      8'h00
`define ICP_NOP_WORD     16'h0000

// ****************************************************************
// Instruction word fields: [15:12] opcode, [11] indirect, [7:0] operand
// ****************************************************************
`define ICP_OPC_HI       15
`define ICP_OPC_LO       12
`define ICP_IND_BIT      11

`define ICP_OP_NOP       4'h0
`define ICP_OP_MOVI      4'h1
`define ICP_OP_ADD       4'h2
`define ICP_OP_AND       4'h3
`define ICP_OP_OR        4'h4
`define ICP_OP_XOR       4'h5
`define ICP_OP_RL        4'h6
`define ICP_OP_INC       4'h7
`define ICP_OP_DEC       4'h8
`define ICP_OP_MOVM      4'h9
`define ICP_OP_SZ        4'ha
`define ICP_OP_MOVPCL    4'hb
`define ICP_OP_LADD      4'hc
`define ICP_OP_JMP       4'hd
`define ICP_OP_CALL      4'he

`endif

// ==== logic/icp_phase_gen.v ====
/*
  Four phase generator. Steps one-hot through the quarter phases on each
  system clock enable. Assumes tick_i is a one-cycle enable on clk_i.
*/
`timescale 1ns/1ps
`default_nettype none
`include "icp_consts.vh"

module icp_phase_gen (
  input  wire       clk_i,
  input  wire       rst_n_i,
  input  wire       tick_i,
  output wire [1:0] phase_o,
  output wire [3:0] quarter_phase_clocks_o
);

  reg [1:0] phase_ff;
  wire [1:0] nxt_phase;

  // ****************************************************************
  // Phase counter, restarts at the first phase after reset
  // ****************************************************************
  assign nxt_phase = tick_i ? phase_ff + 2'h1 : phase_ff;

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phase_ff <= `ICP_PH_T1;
    end else begin
      phase_ff <= nxt_phase;
    end
  end

  assign phase_o = phase_ff;

  // ****************************************************************
  // One-hot decode, exactly one phase active so they never overlap
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < `ICP_NUM_PHASES; g = g + 1) begin : g_ph
      assign quarter_phase_clocks_o[g] = ({30'h0, phase_ff} == g);
    end
  endgenerate

endmodule
`default_nettype wire

// ==== testbench/icp_prog_mem.sv ====
/*
  Program memory model for the instruction cycle pipeline.
  Assumes the bench loads words into mem; unloaded words read as NOP.
*/
`timescale 1ns/1ps
`default_nettype none
module icp_prog_mem (
  input  wire logic [12:0] addr_i,
  output logic      [15:0] data_o
);
  logic [15:0] mem [0:255] = '{default: 16'h0000};
  // Word follows the fetch address with no wait
  assign data_o = mem[addr_i[7:0]];
endmodule
`default_nettype wire

// ==== testbench/icp_pipeline_properties.sv ====
/*
  Checker for the phase and pipeline timing of icp_pipeline.
  Assumes one clock; checks start three edges after reset release.
*/
`timescale 1ns/1ps
`default_nettype none
module icp_pipeline_chk #(
  parameter PC_W = 13
) (
  input wire logic            core_clk_i,
  input wire logic            rstn_i,
  input wire logic            osc_sel_i,
  input wire logic [PC_W-1:0] pm_addr_o,
  input wire logic            pm_rd_o,
  input wire logic [3:0]      quarter_phase_clocks_o,
  input wire logic            sys_tick_o,
  input wire logic            cycle_end_o,
  input wire logic            dummy_cycle_o,
  input wire logic            call_push_o
);
  // ****************************************************************
  // Wait out the internal reset synchroniser
  // ****************************************************************
  logic [1:0] rel_ff;
  logic       live;
  always @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) rel_ff <= 2'h0;
    else if (rel_ff != 2'h3) rel_ff <= rel_ff + 2'h1;
  end
  assign live = (rel_ff == 2'h3);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!live);
  // ****************************************************************
  // Properties
  // ****************************************************************
  property p_onehot;
    $onehot(quarter_phase_clocks_o);
  endproperty
  a_onehot: assert property (p_onehot) else $error("phase clocks overlap");
  property p_step;
    sys_tick_o |=> quarter_phase_clocks_o ==
      {$past(quarter_phase_clocks_o[2:0]), $past(quarter_phase_clocks_o[3])};
  endproperty
  a_step: assert property (p_step) else $error("phase did not advance");
  property p_hold;
    !sys_tick_o |=> $stable(quarter_phase_clocks_o);
  endproperty
  a_hold: assert property (p_hold) else $error("phase moved without tick");
  property p_end;
    cycle_end_o == (sys_tick_o && quarter_phase_clocks_o[3]);
  endproperty
  a_end: assert property (p_end) else $error("cycle end off last phase");
  property p_rd;
    pm_rd_o == quarter_phase_clocks_o[0];
  endproperty
  a_rd: assert property (p_rd) else $error("fetch not in first phase");
  property p_addr;
    !$stable(pm_addr_o) |-> $past(cycle_end_o) && quarter_phase_clocks_o[0];
  endproperty
  a_addr: assert property (p_addr) else $error("fetch address moved mid cycle");
  property p_branch;
    !$stable(pm_addr_o) && pm_addr_o != $past(pm_addr_o) + 1'b1 |-> dummy_cycle_o;
  endproperty
  a_branch: assert property (p_branch) else $error("branch without dummy cycle");
  property p_push;
    call_push_o |-> $past(cycle_end_o) ##1 !call_push_o;
  endproperty
  a_push: assert property (p_push) else $error("call push mistimed");
  property p_slow;
    sys_tick_o && osc_sel_i && $past(osc_sel_i, 4) |=> !sys_tick_o;
  endproperty
  a_slow: assert property (p_slow) else $error("slow source ticks back to back");
  property p_fast;
    !osc_sel_i && !$past(osc_sel_i, 4) |-> sys_tick_o;
  endproperty
  a_fast: assert property (p_fast) else $error("fast source missed a tick");
endmodule
bind icp_pipeline icp_pipeline_chk #(.PC_W(PC_W)) i_icp_pipeline_chk (
  .core_clk_i(core_clk_i), .rstn_i(rstn_i), .osc_sel_i(osc_sel_i),
  .pm_addr_o(pm_addr_o), .pm_rd_o(pm_rd_o),
  .quarter_phase_clocks_o(quarter_phase_clocks_o), .sys_tick_o(sys_tick_o),
  .cycle_end_o(cycle_end_o), .dummy_cycle_o(dummy_cycle_o), .call_push_o(call_push_o));
`default_nettype wire

// ==== testbench/tb_top.sv ====
/*
  Self-checking bench of icp_pipeline with a program memory model.
  Assumes inputs change 2 ns after the rising edge.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        core_clk_i = 1'b0;
  logic        rstn_i = 1'b0;
  logic        osc_sel_i = 1'b0;
  logic [15:0] pm_data;
  logic [12:0] pm_addr, exec_pc, ret_addr;
  logic [12:0] seen_ret = 13'h0000;
  logic [7:0]  acc;
  logic [3:0]  qpc;
  logic        pm_rd, tick, cyc_end, dummy, push;
  int          n_mismatch = 0;
  int          comparisons = 0;
  int          cyc = 0;
  icp_prog_mem i_icp_prog_mem (.addr_i(pm_addr), .data_o(pm_data));
  icp_pipeline i_icp_pipeline (
    .core_clk_i(core_clk_i), .rstn_i(rstn_i), .osc_sel_i(osc_sel_i),
    .pm_data_i(pm_data), .pm_addr_o(pm_addr), .pm_rd_o(pm_rd),
    .quarter_phase_clocks_o(qpc), .sys_tick_o(tick), .cycle_end_o(cyc_end),
    .dummy_cycle_o(dummy), .exec_pc_o(exec_pc), .acc_o(acc),
    .call_push_o(push), .ret_addr_o(ret_addr));
  initial forever #10 core_clk_i = ~core_clk_i;
  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic clk_n(input int n);
    repeat (n) @(posedge core_clk_i);
    #2;
  endtask
  // Step past the next cycle end edge; returns cycles spent
  task automatic next_cycle(output int n);
    n = 0;
    while (cyc_end !== 1'b1 && n < 400) begin
      clk_n(1);
      n++;
    end
    clk_n(1);
    n++;
  endtask
  always @(posedge core_clk_i) begin
    cyc++;
    if (push === 1'b1) seen_ret <= ret_addr;
    if (cyc == 20000) begin
      n_mismatch++;
      stop_test();
    end
  end
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset_vals();
    check(qpc, 16'h1);
    check({pm_rd, dummy, push}, 16'h6);
    check(pm_addr, 16'h0);
    check(acc, 16'h0);
    $display("test reset values done");
  endtask
  task automatic t_program();
    // Bit 15 marks an expected dummy cycle
    logic [15:0] exp [14] = '{16'h0000, 16'h0001, 16'h0002, 16'h0003, 16'h8000,
      16'h0005, 16'h8000, 16'h0008, 16'h8000, 16'h0010, 16'h0011, 16'h8000,
      16'h0020, 16'h0021};
    int n;
    i_icp_prog_mem.mem[8'h00] = 16'h1005;
    i_icp_prog_mem.mem[8'h01] = 16'h9001;
    i_icp_prog_mem.mem[8'h02] = 16'h2001;
    i_icp_prog_mem.mem[8'h03] = 16'ha002;
    i_icp_prog_mem.mem[8'h04] = 16'h10ff;
    i_icp_prog_mem.mem[8'h05] = 16'hd008;
    i_icp_prog_mem.mem[8'h06] = 16'h1077;
    i_icp_prog_mem.mem[8'h08] = 16'he010;
    i_icp_prog_mem.mem[8'h09] = 16'h1066;
    i_icp_prog_mem.mem[8'h10] = 16'h1020;
    i_icp_prog_mem.mem[8'h11] = 16'hb000;
    i_icp_prog_mem.mem[8'h12] = 16'h1055;
    i_icp_prog_mem.mem[8'h20] = 16'h6000;
    i_icp_prog_mem.mem[8'h21] = 16'hc001;
    i_icp_prog_mem.mem[8'h22] = 16'hd022;
    // First cycle after release runs before any word was captured
    clk_n(3);
    check(dummy, 16'h1);
    for (int k = 0; k < 14; k++) begin
      next_cycle(n);
      if (k > 0) check(16'(n), 16'h4);
      check(dummy, exp[k][15]);
      if (!exp[k][15]) check(exec_pc, exp[k][12:0]);
      if (k == 4) check(acc, 16'h0a);
      if (k == 9) check(seen_ret, 16'h9);
      if (k == 12) check(acc, 16'h20);
    end
    clk_n(16);
    check(acc, 16'h45);
    $display("test program flow done");
  endtask
  task automatic t_slow();
    int n;
    osc_sel_i = 1'b1;
    next_cycle(n);
    next_cycle(n);
    next_cycle(n);
    check(16'(n), 16'h20);
    osc_sel_i = 1'b0;
    next_cycle(n);
    next_cycle(n);
    check(16'(n), 16'h4);
    $display("test clock source done");
  endtask
  task automatic t_mid_reset();
    clk_n(3);
    rstn_i = 1'b0;
    clk_n(3);
    t_reset_vals();
    rstn_i = 1'b1;
    clk_n(2);
    check(qpc, 16'h1);
    clk_n(4);
    check(pm_addr, 16'h1);
    $display("test mid-run reset done");
  endtask
  task automatic t_alu();
    // Accumulator after each instruction; location 0 is the pointer
    logic [7:0] exp [12] = '{8'h03, 8'h03, 8'h0c, 8'h0c, 8'h0a, 8'h06,
      8'h0e, 8'h0c, 8'h0c, 8'h19, 8'h19, 8'h25};
    logic [15:0] prog [12] = '{16'h1003, 16'h9000, 16'h100c, 16'h9803,
      16'h100a, 16'h5003, 16'h4003, 16'h3003, 16'h7003, 16'h2803,
      16'h8003, 16'h2003};
    int n;
    rstn_i = 1'b0;
    for (int k = 0; k < 12; k++) i_icp_prog_mem.mem[k] = prog[k];
    clk_n(3);
    rstn_i = 1'b1;
    clk_n(3);
    next_cycle(n);
    for (int k = 0; k < 12; k++) begin
      next_cycle(n);
      check(acc, exp[k]);
    end
    $display("test arithmetic unit done");
  endtask
  initial begin
    clk_n(20);
    t_reset_vals();
    rstn_i = 1'b1;
    t_program();
    t_slow();
    t_mid_reset();
    t_alu();
    stop_test();
  end
endmodule
`default_nettype wire
